// *** adc_conversion_sequencer.sv ***
// Contract
// R1: Each 10-bit result takes eleven conversion clock periods once conversion begins.
// R2: Clock select 000/100/001/101/010/110 give 2/4/8/16/32/64; x11 picks RC.
// R3: Software picks the shortest conversion clock period above the minimum.
// R4: RC clock with device clock above 1 MHz needs Sleep for the conversion.
// R5: Keep the same device clock source until a started conversion completes.
// R6: Software selects the RC conversion clock below 1 MHz device clock.
// R7: Converting in Sleep is allowed only with the RC conversion clock.
// R8: Acquisition field zero delays conversion start by one instruction cycle.
// R9: Software clears the idle-on-sleep select before a Sleep conversion.
// R10: Conversion runs regardless of channel select and pin direction.
// R11: Port reads return zero for every pin configured as analog.
// R12: A configuration strap sets the reset value of port-B analog bits.
// R13: Clearing go aborts; result registers keep their previous value.
// R14: After completion or abort wait two periods, then acquire again.
// R15: Software does not set go in the write that turns converter on.
// R16: Capacitor array is discharged before every sampling phase.
// R17: Acquisition field 010 inserts four periods of acquisition before conversion.
// R18: Compare event in mode 1011 with converter on sets go, clears timer.
// R19: With converter off the event starts nothing but still clears timer.
// R20: Software selects channel and ensures acquisition before an event trigger.
// R21: Completion loads result pair, clears go and sets the done flag.
// R22: Acquisition field maps 0..7 to 0,2,4,6,8,12,16,20 periods.
// R23: Result format set right-justifies, clear left-justifies the result.
// R24: Reset switches the converter off and aborts any conversion.
// R25: Conversion clock is one enable pulse per period, divided or from RC.
// R26: States discharge, acquire, convert, wait; leave acquire only on go.
`timescale 1ns/1ps
package adc_seq_pkg;
    localparam int          CLK_NS       = 50;
    localparam int          TCY_NS       = 200;
    localparam int          TCY_CYC_INT  = (TCY_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [5:0]  TCY_CYC      = 6'(TCY_CYC_INT);
    localparam logic [5:0]  CONV_TADS    = 6'h0b;
    localparam logic [5:0]  WAIT_TADS    = 6'h02;
    localparam logic [5:0]  DISCH_TADS   = 6'h01;
    localparam int          RES_W        = 10;
    localparam int          N_PINS       = 13;
    localparam logic [12:0] PB_MASK      = 13'h1f00;
    localparam logic [12:0] PIN_CFG_RST  = 13'h1fff;
    localparam logic [3:0]  TRIG_MODE    = 4'hb;
    localparam logic [1:0]  RC_CODE      = 2'h3;
    // Register byte offsets
    localparam logic [7:0]  OFF_CTRL0    = 8'h00;
    localparam logic [7:0]  OFF_CTRL1    = 8'h04;
    localparam logic [7:0]  OFF_RESH     = 8'h08;
    localparam logic [7:0]  OFF_RESL     = 8'h0c;
    localparam logic [7:0]  OFF_PINCFG   = 8'h10;
    localparam logic [7:0]  OFF_PORT     = 8'h14;
    localparam logic [7:0]  OFF_STATUS   = 8'h18;
    // Field positions
    localparam int          B_ON         = 0;
    localparam int          B_GO         = 1;
    localparam int          B_CHAN       = 2;
    localparam int          B_CLKSEL     = 0;
    localparam int          B_ACQ        = 3;
    localparam int          B_FMT        = 7;
    localparam int          B_DONE       = 0;
    localparam int          B_STATE      = 8;
    localparam logic [2:0]  CLKSEL_RST   = 3'h0;
    localparam logic [2:0]  ACQ_RST      = 3'h0;

    typedef enum logic [5:0] {
        ST_OFF    = 6'h01,
        ST_DISCH  = 6'h02,
        ST_ACQ    = 6'h04,
        ST_DELAY  = 6'h08,
        ST_CONV   = 6'h10,
        ST_WAIT   = 6'h20
    } seq_state_t;

    // Acquisition periods per field code
    function automatic logic [5:0] acq_tads(input logic [2:0] code);
        unique case (code)
            3'h0: acq_tads = 6'h00;
            3'h1: acq_tads = 6'h02;
            3'h2: acq_tads = 6'h04;
            3'h3: acq_tads = 6'h06;
            3'h4: acq_tads = 6'h08;
            3'h5: acq_tads = 6'h0c;
            3'h6: acq_tads = 6'h10;
            3'h7: acq_tads = 6'h14;
        endcase
    endfunction : acq_tads

    // Oscillator periods per conversion clock, minus one
    function automatic logic [5:0] div_last(input logic [2:0] code);
        unique case (code)
            3'h0:    div_last = 6'h01;
            3'h4:    div_last = 6'h03;
            3'h1:    div_last = 6'h07;
            3'h5:    div_last = 6'h0f;
            3'h2:    div_last = 6'h1f;
            3'h6:    div_last = 6'h3f;
            default: div_last = 6'h3f;
        endcase
    endfunction : div_last
endpackage : adc_seq_pkg

module adc_conversion_sequencer (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         rc_clk,
    input  wire logic                         comp_above,
    input  wire logic [adc_seq_pkg::N_PINS-1:0] port_pins,
    input  wire logic                         portb_analog_reset_cfg,
    input  wire logic [3:0]                   compare_mode_field,
    input  wire logic                         special_event,
    output logic      [3:0]                   channel_select,
    output logic      [adc_seq_pkg::N_PINS-1:0] pin_analog_cfg,
    output logic                              discharge_en,
    output logic                              sample_en,
    output logic                              converting,
    output logic      [9:0]                   dac_code,
    output logic                              timer_clear
);
    import adc_seq_pkg::*;

    typedef struct packed {
        seq_state_t          state;
        logic                converter_on;
        logic                go;
        logic [3:0]          chan;
        logic [2:0]          conv_clock_select;
        logic [2:0]          acq_time_select;
        logic                result_format;
        logic [7:0]          result_high;
        logic [7:0]          result_low;
        logic [N_PINS-1:0]   pin_cfg;
        logic                strap_done;
        logic                conv_done_flag;
        logic [5:0]          cnt;
        logic                tcy_mode;
        logic [9:0]          sar;
        logic                comp_m;
        logic                comp_s;
        logic [N_PINS-1:0]   port_m;
        logic [N_PINS-1:0]   port_s;
        logic [31:0]         rdata;
        logic                slverr;
        logic                timer_clr;
    } seq_regs_t;

    seq_regs_t st_r;
    seq_regs_t st_nxt;
    logic      tad_pulse;
    logic      wr_acc;
    logic      setup;
    logic      trig;

    ////////////////////////////////////////////////////////////////////////
    conv_clock_gen u_clkgen (
        .clk               (clk),
        .resetn            (resetn),
        .enable            (st_r.converter_on),
        .conv_clock_select (st_r.conv_clock_select),
        .rc_clk            (rc_clk),
        .tad_pulse         (tad_pulse)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one setup, one access cycle, no waits
    assign setup   = psel && !penable;
    assign pready  = psel && penable;
    assign wr_acc  = psel && penable && pwrite;
    assign prdata  = st_r.rdata;
    assign pslverr = pready && st_r.slverr;
    assign trig    = special_event && (compare_mode_field == TRIG_MODE);

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFF_CTRL0) || (a == OFF_CTRL1) || (a == OFF_RESH)
              || (a == OFF_RESL) || (a == OFF_PINCFG) || (a == OFF_PORT)
              || (a == OFF_STATUS);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [9:0] res;
        res    = st_r.sar;
        st_nxt = st_r;
        st_nxt.timer_clr = 1'b0;

        // Pin and comparator synchronisers
        st_nxt.comp_m = comp_above;
        st_nxt.comp_s = st_r.comp_m;
        st_nxt.port_m = port_pins;
        st_nxt.port_s = st_r.port_m;

        // Strap is taken on the first edge after reset release
        if (!st_r.strap_done) begin
            st_nxt.strap_done = 1'b1;
            st_nxt.pin_cfg    = (PIN_CFG_RST & ~PB_MASK)
                | (portb_analog_reset_cfg ? PB_MASK : '0); // [R12]
        end

        // Read data is captured in the setup phase
        if (setup) begin
            st_nxt.slverr = !mapped(paddr);
            st_nxt.rdata  = '0;
            unique case (paddr)
                OFF_CTRL0: begin
                    st_nxt.rdata[B_ON]          = st_r.converter_on;
                    st_nxt.rdata[B_GO]          = st_r.go;
                    st_nxt.rdata[B_CHAN+:4]     = st_r.chan;
                end
                OFF_CTRL1: begin
                    st_nxt.rdata[B_CLKSEL+:3]   = st_r.conv_clock_select;
                    st_nxt.rdata[B_ACQ+:3]      = st_r.acq_time_select;
                    st_nxt.rdata[B_FMT]         = st_r.result_format;
                end
                OFF_RESH:   st_nxt.rdata[7:0] = st_r.result_high;
                OFF_RESL:   st_nxt.rdata[7:0] = st_r.result_low;
                OFF_PINCFG: st_nxt.rdata[N_PINS-1:0] = st_r.pin_cfg;
                OFF_PORT:   st_nxt.rdata[N_PINS-1:0] =
                                st_r.port_s & ~st_r.pin_cfg; // [R11]
                OFF_STATUS: begin
                    st_nxt.rdata[B_DONE]        = st_r.conv_done_flag;
                    st_nxt.rdata[B_STATE+:6]    = st_r.state;
                end
                default:    st_nxt.rdata = '0;
            endcase
        end

        // Register writes take effect at the access edge
        if (wr_acc) begin
            unique case (paddr)
                OFF_CTRL0: begin
                    st_nxt.converter_on = pwdata[B_ON];
                    st_nxt.chan         = pwdata[B_CHAN+:4];
                    // Go only counts if the converter was already on
                    st_nxt.go = pwdata[B_GO] && st_r.converter_on
                                && pwdata[B_ON]; // [R15]
                end
                OFF_CTRL1: begin
                    st_nxt.conv_clock_select = pwdata[B_CLKSEL+:3];
                    st_nxt.acq_time_select   = pwdata[B_ACQ+:3];
                    st_nxt.result_format     = pwdata[B_FMT];
                end
                OFF_RESH:   st_nxt.result_high = pwdata[7:0];
                OFF_RESL:   st_nxt.result_low  = pwdata[7:0];
                OFF_PINCFG: st_nxt.pin_cfg     = pwdata[N_PINS-1:0];
                OFF_STATUS: if (pwdata[B_DONE]) begin
                    st_nxt.conv_done_flag = 1'b0;
                end
                default: ;
            endcase
        end

        // Trigger clears the timer whether or not the converter is on
        if (trig) begin
            st_nxt.timer_clr = 1'b1; // [R19]
            if (st_r.converter_on && st_nxt.converter_on) begin
                st_nxt.go = 1'b1; // [R18]
            end
        end

        // Sequencer
        unique case (st_r.state)
            ST_OFF: begin
                if (st_nxt.converter_on) begin
                    st_nxt.state = ST_DISCH; // [R16]
                    st_nxt.cnt   = '0;
                end
            end
            ST_DISCH: begin
                if (tad_pulse) begin
                    st_nxt.cnt = st_r.cnt + 6'h01;
                    if (st_r.cnt + 6'h01 >= DISCH_TADS) begin
                        st_nxt.state = ST_ACQ; // [R26]
                        st_nxt.cnt   = '0;
                    end
                end
            end
            ST_ACQ: begin
                if (st_r.go) begin // [R26]
                    st_nxt.state    = ST_DELAY;
                    st_nxt.cnt      = '0;
                    // Zero acquisition still waits one instruction cycle
                    st_nxt.tcy_mode = (st_r.acq_time_select == 3'h0); // [R8]
                end
            end
            ST_DELAY: begin
                if (!st_nxt.go) begin
                    st_nxt.state = ST_WAIT; // [R13]
                    st_nxt.cnt   = '0;
                end else if (st_r.tcy_mode) begin
                    st_nxt.cnt = st_r.cnt + 6'h01;
                    if (st_r.cnt + 6'h01 >= TCY_CYC) begin
                        st_nxt.state = ST_CONV; // [R8]
                        st_nxt.cnt   = '0;
                    end
                end else if (tad_pulse) begin
                    st_nxt.cnt = st_r.cnt + 6'h01;
                    if (st_r.cnt + 6'h01
                            >= acq_tads(st_r.acq_time_select)) begin
                        st_nxt.state = ST_CONV; // [R17] [R22]
                        st_nxt.cnt   = '0;
                    end
                end
            end
            ST_CONV: begin
                if (!st_nxt.go) begin
                    // Partial result never reaches the result pair
                    st_nxt.state = ST_WAIT; // [R13]
                    st_nxt.cnt   = '0;
                    st_nxt.sar   = '0;
                end else if (tad_pulse) begin
                    st_nxt.cnt = st_r.cnt + 6'h01;
                    if (st_r.cnt == 6'h00) begin
                        st_nxt.sar = 10'h200;
                    end else begin
                        // Decide bit 10-cnt, then trial the next one
                        res = st_r.sar;
                        if (!st_r.comp_s) begin
                            res[4'(RES_W) - st_r.cnt[3:0]] = 1'b0;
                        end
                        if (st_r.cnt < 6'(RES_W)) begin
                            res[4'(RES_W - 1) - st_r.cnt[3:0]] = 1'b1;
                        end
                        st_nxt.sar = res;
                    end
                    if (st_r.cnt + 6'h01 >= CONV_TADS) begin // [R1]
                        st_nxt.state          = ST_WAIT;
                        st_nxt.cnt            = '0;
                        st_nxt.go             = 1'b0; // [R21]
                        st_nxt.conv_done_flag = 1'b1; // [R21]
                        if (st_r.result_format) begin // [R23]
                            st_nxt.result_high = {6'h00, res[9:8]};
                            st_nxt.result_low  = res[7:0];
                        end else begin
                            st_nxt.result_high = res[9:2];
                            st_nxt.result_low  = {res[1:0], 6'h00};
                        end
                    end
                end
            end
            ST_WAIT: begin
                if (tad_pulse) begin
                    st_nxt.cnt = st_r.cnt + 6'h01;
                    if (st_r.cnt + 6'h01 >= WAIT_TADS) begin
                        st_nxt.state = ST_DISCH; // [R14] [R16]
                        st_nxt.cnt   = '0;
                    end
                end
            end
        endcase

        // Switching off aborts wherever the sequencer is
        if (!st_nxt.converter_on) begin
            st_nxt.state = ST_OFF; // [R24]
            st_nxt.go    = 1'b0;
            st_nxt.cnt   = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result pair is cleared by every reset here, unlike the real part; zero is
    // loaded so that simulation starts from a known value.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r                   <= '0; // [R24]
            st_r.state             <= ST_OFF;
            st_r.conv_clock_select <= CLKSEL_RST;
            st_r.acq_time_select   <= ACQ_RST;
            st_r.pin_cfg           <= PIN_CFG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel mux runs from the register alone; pin direction is ignored
    assign channel_select = st_r.chan; // [R10]
    assign pin_analog_cfg = st_r.pin_cfg;
    assign discharge_en   = st_r.state == ST_DISCH;
    assign sample_en      = (st_r.state == ST_ACQ)
                          || (st_r.state == ST_DELAY);
    assign converting     = st_r.state == ST_CONV;
    assign dac_code       = st_r.sar;
    assign timer_clear    = st_r.timer_clr;
endmodule : adc_conversion_sequencer

// *** conv_clock_gen.sv ***
`timescale 1ns/1ps
module conv_clock_gen (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       enable,
    input  wire logic [2:0] conv_clock_select,
    input  wire logic       rc_clk,
    output logic            tad_pulse
);
    import adc_seq_pkg::*;

    typedef struct packed {
        logic [5:0] div;
        logic       rc_m;
        logic       rc_s;
        logic       rc_d;
        logic       pulse;
    } clkgen_regs_t;

    clkgen_regs_t st_r;
    clkgen_regs_t st_nxt;

    always_comb begin
        logic [5:0] last;
        last      = div_last(conv_clock_select);
        st_nxt    = st_r;
        // RC source crosses in via two flops; edge seen after the second
        st_nxt.rc_m  = rc_clk;
        st_nxt.rc_s  = st_r.rc_m;
        st_nxt.rc_d  = st_r.rc_s;
        st_nxt.pulse = 1'b0;
        if (!enable) begin
            st_nxt.div = '0;
        end else if (conv_clock_select[1:0] == RC_CODE) begin // [R2]
            st_nxt.div   = '0;
            st_nxt.pulse = st_r.rc_s && !st_r.rc_d; // [R25]
        end else if (st_r.div >= last) begin
            // Also recovers when the divide is shortened mid-count
            st_nxt.div   = '0;
            st_nxt.pulse = 1'b1; // [R2] [R25]
        end else begin
            st_nxt.div = st_r.div + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tad_pulse = st_r.pulse;
endmodule : conv_clock_gen

// *** adc_seq_properties.sv ***
`timescale 1ns/1ps
module adc_seq_properties (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  compare_mode_field,
    input wire logic        special_event,
    input wire logic [3:0]  channel_select,
    input wire logic        discharge_en,
    input wire logic        sample_en,
    input wire logic        converting,
    input wire logic        timer_clear
);
    logic trig_hit;
    logic wr_ctrl0;
    assign trig_hit = special_event && compare_mode_field == 4'hb;
    assign wr_ctrl0 = psel && penable && pwrite && paddr == 8'h00;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_trig;
        special_event && compare_mode_field == 4'hb;
    endsequence
    // Wait phase: no sampling for three samples, and no discharging in the first
    sequence s_idle_wait;
        !sample_en && !discharge_en ##1 !sample_en [*2];
    endsequence
    a_ready_access: assert property (pready == (psel && penable))
        else $error("pready not tied to access phase");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response outside access or with data");
    a_trig_clear: assert property (s_trig |=> timer_clear)
        else $error("timer clear missing after trigger");
    a_clear_cause: assert property (timer_clear |-> $past(trig_hit))
        else $error("timer clear without trigger");
    a_disch_first: assert property ($rose(sample_en) |-> $past(discharge_en))
        else $error("sampling began without discharge");
    a_disch_excl: assert property (discharge_en |-> !sample_en)
        else $error("discharge overlaps sampling");
    a_conv_excl: assert property (converting |-> !sample_en && !discharge_en)
        else $error("conversion overlaps another phase");
    a_wait_after: assert property ($fell(converting) |-> s_idle_wait)
        else $error("acquisition resumed without wait");
    a_chan_write: assert property ($changed(channel_select) |-> $past(wr_ctrl0))
        else $error("channel changed without a write");
endmodule : adc_seq_properties

bind adc_conversion_sequencer adc_seq_properties chk (.clk, .resetn, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .compare_mode_field,
    .special_event, .channel_select, .discharge_en, .sample_en, .converting,
    .timer_clear);

// *** analog_front_model.sv ***
`timescale 1ns/1ps
module analog_front_model (
    input  wire logic [9:0]  dac_code,
    input  wire logic [9:0]  level,
    input  wire logic [12:0] pin_level,
    output logic             comp_above,
    output logic [12:0]      port_pins,
    output logic             rc_clk
);
    // Half-step offset so a tie resolves upward and the code equals level
    assign comp_above = {1'b0, level, 1'b1} > {1'b0, dac_code, 1'b0};
    assign port_pins = pin_level;
    // RC source runs free, unrelated in phase to the system clock
    // No Sleep modelled; RC codes test logic only
    initial begin
        rc_clk = 1'b0;
        #37;
        forever #200 rc_clk = ~rc_clk;
    end
endmodule : analog_front_model

// *** adc_conversion_sequencer_test.sv ***
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
    import adc_seq_pkg::*;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, er;
    logic        rc_clk, comp_above, strap, special_event, timer_clear;
    logic        discharge_en, sample_en, converting, last_f;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  mode, chan;
    logic [12:0] pins, pin_lvl, pcfg, cfg;
    logic [9:0]  dac, level;
    int          bad_count, total_checks, seed, last_r, n;
    int          div_of[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
    int          acq_of[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int          cs_list[7] = '{0, 4, 1, 5, 2, 6, 3};
    int          q[$];

    adc_conversion_sequencer dut (.clk, .resetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .rc_clk, .comp_above,
        .port_pins(pins), .portb_analog_reset_cfg(strap),
        .compare_mode_field(mode), .special_event, .channel_select(chan),
        .pin_analog_cfg(pcfg), .discharge_en, .sample_en, .converting,
        .dac_code(dac), .timer_clear);
    analog_front_model far (.dac_code(dac), .level, .pin_level(pin_lvl),
        .comp_above, .port_pins(pins), .rc_clk);

    // Clock never switched, never below 1 MHz
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task check(input string nm, input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, x, s);
        end
    endtask : check
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        do
            @(posedge clk);
        while (!pready);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task pulse;
        special_event <= 1'b1;
        @(posedge clk) special_event <= 1'b0;
        @(posedge clk);
    endtask : pulse
    task wait_sample;
        n = 0;
        while (!sample_en && n < 5000) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_sample
    task chk_res(input int r, input logic f);
        apb(0, OFF_RESH, 0);
        check("result_high", rd, f ? 32'(r >> 8) : 32'(r >> 2));
        apb(0, OFF_RESL, 0);
        check("result_low", rd, f ? 32'(r & 255) : 32'((r & 3) << 6));
    endtask : chk_res
    task conv(input logic [2:0] cs, input logic [2:0] aq, input logic fm,
              input logic trig);
        int g, m, d;
        logic [9:0] lv;
        logic [3:0] ch;
        lv = 10'($random(seed));
        ch = 4'($random(seed));
        d = div_of[cs];
        level <= lv;
        q.push_back(int'(lv));
        apb(1, OFF_CTRL1, {24'h0, fm, 1'b0, aq, cs});
        apb(1, OFF_CTRL0, {26'h0, ch, 2'b01});
        wait_sample;
        if (trig) begin
            pulse;
            check("timer_clear", 32'(timer_clear), 32'h1);
        end else apb(1, OFF_CTRL0, {26'h0, ch, 2'b11});
        g = 0;
        while (!converting && g < 3000) begin
            @(posedge clk);
            g++;
        end
        m = 0;
        while (converting && m < 3000) begin
            @(posedge clk);
            m++;
        end
        if (d > 0 && !trig) begin
            check("acq_gap", 32'(aq == 0 ? g >= 2 && g <= 6 :
                g >= (acq_of[aq] - 1) * d && g <= acq_of[aq] * d + 4), 1);
            check("conv_len", 32'(m > 10 * d && m <= 11 * d + 1), 1);
        end
        check("channel", 32'(chan), 32'(ch));
        last_r = q.pop_front();
        last_f = fm;
        // Fastest divider leaves the comparator no settling margin
        if (cs != 3'h0) chk_res(last_r, fm);
        apb(0, OFF_STATUS, 0);
        check("done_flag", 32'(rd[0]), 32'h1);
        apb(0, OFF_CTRL0, 0);
        check("go_cleared", 32'(rd[1]), 32'h0);
        apb(1, OFF_STATUS, 32'h1);
    endtask : conv
    ////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        {psel, penable, pwrite, strap, special_event} = '0;
        paddr = '0;
        pwdata = '0;
        mode = 4'hb;
        level = '0;
        pin_lvl = '0;
        seed = 32'hd59f1428;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        check("pin_cfg_reset", 32'(pcfg), 32'h00ff);
        apb(0, OFF_STATUS, 0);
        check("state_off", 32'(rd[13:8]), 32'h01);
        apb(0, 8'h1c, 0);
        check("unmapped_err", 32'(er), 32'h1);
        check("unmapped_data", rd, 32'h0);
        foreach (cs_list[i]) conv(3'(cs_list[i]), 3'(i), 1'(i), 1'b0);
        conv(3'h1, 3'h7, 1'b1, 1'b1);
        // Abort mid-conversion with the slowest divider
        apb(1, OFF_CTRL1, 32'h06);
        wait_sample;
        apb(1, OFF_CTRL0, 32'h3);
        repeat (100) @(posedge clk);
        apb(1, OFF_CTRL0, 32'h1);
        check("abort_stop", 32'(converting), 32'h0);
        chk_res(last_r, last_f);
        apb(0, OFF_STATUS, 0);
        check("abort_done", 32'(rd[0]), 32'h0);
        wait_sample;
        check("reacquire", 32'(sample_en), 32'h1);
        apb(1, OFF_CTRL0, 32'h0);
        pulse;
        check("clear_when_off", 32'(timer_clear), 32'h1);
        repeat (20) @(posedge clk);
        apb(0, OFF_STATUS, 0);
        check("off_ignores", 32'(rd[13:8]), 32'h01);
        mode <= 4'ha;
        apb(1, OFF_CTRL0, 32'h1);
        pulse;
        check("wrong_mode", 32'(timer_clear), 32'h0);
        cfg = 13'($random(seed));
        pin_lvl <= 13'($random(seed));
        apb(1, OFF_PINCFG, {19'h0, cfg});
        apb(0, OFF_PINCFG, 0);
        check("pin_cfg", rd, {19'h0, cfg});
        apb(0, OFF_PORT, 0);
        check("port_read", rd, {19'h0, pin_lvl & ~cfg});
        strap <= 1'b1;
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        check("strap_analog", 32'(pcfg), 32'h1fff);
        check("reset_off", 32'(sample_en), 32'h0);
        final_report;
    end
    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        final_report;
    end
endmodule : adc_conversion_sequencer_test
